// ===== design/ebd_pkg.sv
package ebd_pkg;
  // ==========================================================
  // area codes from physical address bits 28..26
  localparam int          AREA_LSB   = 26;
  localparam int          AREA_MSB   = 28;
  localparam logic [2:0]  AREA0_CODE = 3'h0;
  localparam logic [2:0]  AREA1_CODE = 3'h1;
  localparam logic [2:0]  AREA2_CODE = 3'h2;
  localparam logic [2:0]  AREA3_CODE = 3'h3;
  localparam logic [2:0]  AREA4_CODE = 3'h4;
  // ==========================================================
  // size encodings (mode pins and size fields)
  localparam logic [1:0]  SZ_BYTE    = 2'h1;
  localparam logic [1:0]  SZ_WORD    = 2'h2;
  localparam logic [1:0]  SZ_LONG    = 2'h3;
  localparam logic [1:0]  SZ_BUS32   = 2'h0;
  // ==========================================================
  // wait limits
  localparam logic [3:0]  WAIT_MAX_LONG  = 4'ha;
  localparam logic [3:0]  WAIT_MAX_SHORT = 4'h3;
  localparam logic [3:0]  BURST_PITCH_MIN = 4'h2;
  localparam logic [3:0]  BURST_PITCH_MAX = 4'ha;
  localparam logic [3:0]  RESET_WAIT     = 4'h0;
endpackage

// ===== design/ebd_wait_map.sv
// ==========================================================
// maps a wait field to a saturated wait count
module ebd_wait_map #(
  parameter logic [3:0] MAX_WAIT = 4'ha
) (
  input  wire logic [2:0] waitField,
  output wire logic [3:0] waitCount
);
  // fields beyond the documented span clamp rather than overrun
  assign waitCount = ({1'b0, waitField} > MAX_WAIT) ? MAX_WAIT : {1'b0, waitField};
endmodule

// ===== design/ebd_bridge.sv
module ebd_bridge (
  input  wire logic        clk_sys,
  input  wire logic        rst,
  // request from internal bus
  input  wire logic        reqValid,
  input  wire logic [31:0] reqAddr,
  input  wire logic [1:0]  reqSize,
  input  wire logic        reqWrite,
  input  wire logic [31:0] reqWdata,
  input  wire logic        burstEn,
  output logic             reqReady,
  output logic             rspValid,
  output logic [31:0]      rspRdata,
  output logic             periphSel,
  // configuration bits
  input  wire logic        width_mode_pin_low,
  input  wire logic        width_mode_pin_high,
  input  wire logic [2:0]  area0_wait_field,
  input  wire logic        area2_wait_field_high,
  input  wire logic        area2_wait_field_low,
  input  wire logic        area3_wait_field_high,
  input  wire logic        area3_wait_field_low,
  input  wire logic [2:0]  area4_wait_field,
  input  wire logic        area2_size_field_high,
  input  wire logic        area2_size_field_low,
  input  wire logic        area3_size_field_high,
  input  wire logic        area3_size_field_low,
  input  wire logic [1:0]  sdramAreas,
  input  wire logic [3:0]  sdramColBits,
  input  wire logic [3:0]  area4Size,
  // external pins
  output logic [25:0]      extAddr,
  output logic [31:0]      extDout,
  output logic             extDoe,
  input  wire logic [31:0] extDin,
  output logic             area0_chip_select_n,
  output logic             area2_chip_select_n,
  output logic             area3_chip_select_n,
  output logic             area4_chip_select_n,
  output logic             readStrobe_n,
  output logic [3:0]       byte_write_strobes_n,
  output logic             row_strobe_upper_n,
  output logic             row_strobe_lower_n,
  output logic             column_strobe_upper_n,
  output logic             column_strobe_lower_n,
  output logic             sdramReadNotWrite,
  output logic             byte_mask_lane0,
  output logic             byte_mask_lane1,
  output logic             byte_mask_lane2,
  output logic             byte_mask_lane3,
  output logic             burstPitchTick
);
  typedef enum logic [1:0] {EBD_IDLE, EBD_ACCESS, EBD_DONE} ebd_state_t;

  // ==========================================================
  // synchronise the mode pins, they come from the board
  logic [1:0] modeMeta_q;
  logic [1:0] modeSync_q;
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      modeMeta_q <= 2'h0;
      modeSync_q <= 2'h0;
    end else begin
      modeMeta_q <= {width_mode_pin_high, width_mode_pin_low};
      modeSync_q <= modeMeta_q;
    end
  end

  // ==========================================================
  // area decode; bits 31..29 never looked at so shadows alias
  wire logic [2:0] areaCode = reqAddr[ebd_pkg::AREA_MSB:ebd_pkg::AREA_LSB];
  wire logic hitA0 = areaCode == ebd_pkg::AREA0_CODE;
  wire logic hitA1 = areaCode == ebd_pkg::AREA1_CODE;
  wire logic hitA2 = areaCode == ebd_pkg::AREA2_CODE;
  wire logic hitA3 = areaCode == ebd_pkg::AREA3_CODE;
  wire logic hitA4 = areaCode == ebd_pkg::AREA4_CODE;
  wire logic hitSd = (hitA2 & sdramAreas[0]) | (hitA3 & sdramAreas[1]);

  // ==========================================================
  // port width per area; mode pins only feed area 0
  wire logic [1:0] a2Sz = {area2_size_field_high, area2_size_field_low};
  wire logic [1:0] a3Sz = {area3_size_field_high, area3_size_field_low};
  wire logic [1:0] busWidth =
      hitA0 ? modeSync_q :
      hitA2 ? a2Sz :
      hitA3 ? a3Sz :
      area4Size[1:0];

  // ==========================================================
  // wait counts per area; areas 0 and 4 clamped to the documented span, areas 2 and 3 used as given
  logic [3:0] wA0;
  logic [3:0] wA4;
  ebd_wait_map #(.MAX_WAIT(ebd_pkg::WAIT_MAX_LONG)) uWait0 (
    .waitField (area0_wait_field),
    .waitCount (wA0)
  );
  ebd_wait_map #(.MAX_WAIT(ebd_pkg::WAIT_MAX_LONG)) uWait4 (
    .waitField (area4_wait_field),
    .waitCount (wA4)
  );
  wire logic [3:0] wA2 = {2'h0, area2_wait_field_high, area2_wait_field_low};
  wire logic [3:0] wA3 = {2'h0, area3_wait_field_high, area3_wait_field_low};
  wire logic [3:0] waitSel = hitA0 ? wA0 : hitA2 ? wA2 : hitA3 ? wA3 : hitA4 ? wA4 :
                             ebd_pkg::RESET_WAIT;

  // ==========================================================
  // number of narrow beats for a request on this port
  wire logic [2:0] beatsNeeded =
      (busWidth == ebd_pkg::SZ_BYTE) ?
        ((reqSize == ebd_pkg::SZ_LONG) ? 3'h4 :
         (reqSize == ebd_pkg::SZ_WORD) ? 3'h2 : 3'h1) :
      (busWidth == ebd_pkg::SZ_WORD) ?
        ((reqSize == ebd_pkg::SZ_LONG) ? 3'h2 : 3'h1) : 3'h1;

  // ==========================================================
  // latched request
  ebd_state_t  state_q;
  logic [31:0] addr_q;
  logic [1:0]  size_q;
  logic [1:0]  width_q;
  logic        write_q;
  logic [31:0] wdata_q;
  logic [31:0] rdata_q;
  logic [3:0]  waitLoad_q;
  logic [3:0]  waitCnt_q;
  logic [2:0]  beat_q;
  logic [2:0]  beats_q;
  logic        a0_q;
  logic        a2_q;
  logic        a3_q;
  logic        a4_q;
  logic        sd_q;
  logic        burst_q;
  logic        capEn_q;
  wire logic extHit = hitA0 | hitA2 | hitA3 | hitA4;
  wire logic accept = reqValid & ~reqReady & (state_q == EBD_IDLE); // valid stands while ready shows
  wire logic beatEnd = (state_q == EBD_ACCESS) & (waitCnt_q == ebd_pkg::RESET_WAIT);
  wire logic lastBeat = beat_q == (beats_q - 3'h1);
  wire logic [3:0] burstLoad = (waitLoad_q < ebd_pkg::BURST_PITCH_MIN - 4'h1) ?
      ebd_pkg::BURST_PITCH_MIN - 4'h1 : (waitLoad_q > ebd_pkg::BURST_PITCH_MAX - 4'h1) ?
      ebd_pkg::BURST_PITCH_MAX - 4'h1 : waitLoad_q;
  // byte offset of the current beat within the request
  wire logic [1:0] beatOff = (width_q == ebd_pkg::SZ_BYTE) ? beat_q[1:0] :
                             (width_q == ebd_pkg::SZ_WORD) ? {beat_q[0], 1'b0} : 2'h0;
  wire logic [1:0] curLow = 2'(addr_q[1:0] + beatOff);
  // pins show a beat one clock after the sequencer moves on; reads follow the pins
  wire logic [2:0] pinBeat = (state_q == EBD_DONE) ? beat_q : beat_q - 3'h1;
  wire logic [1:0] rdOff = (width_q == ebd_pkg::SZ_BYTE) ? pinBeat[1:0] :
                           (width_q == ebd_pkg::SZ_WORD) ? {pinBeat[0], 1'b0} : 2'h0;
  // ==========================================================
  // lane steering: source byte for this beat and target lane
  wire logic [7:0]  srcByte = wdata_q[{beatOff, 3'h0} +: 8];
  wire logic [15:0] srcHalf = wdata_q[{beatOff[1], 4'h0} +: 16];
  logic [31:0] laneData;
  logic [3:0]  laneEn;
  always_comb begin
    laneData = 32'h0000_0000;
    laneEn   = 4'h0;
    unique case (width_q)
      ebd_pkg::SZ_BYTE: begin
        laneData = {24'h00_0000, srcByte};
        laneEn   = 4'h1;
      end
      ebd_pkg::SZ_WORD: begin
        if (size_q == ebd_pkg::SZ_BYTE) begin
          laneData = curLow[0] ? {16'h0000, srcByte, 8'h00} : {24'h00_0000, srcByte};
          laneEn   = curLow[0] ? 4'h2 : 4'h1;
        end else begin
          laneData = {16'h0000, srcHalf};
          laneEn   = 4'h3;
        end
      end
      default: begin
        laneData = wdata_q << {addr_q[1:0], 3'h0};
        laneEn   = (size_q == ebd_pkg::SZ_BYTE) ? (4'h1 << addr_q[1:0]) :
                   (size_q == ebd_pkg::SZ_WORD) ? (addr_q[1] ? 4'hc : 4'h3) : 4'hf;
      end
    endcase
  end
  // read gather: lane(s) into result position for this beat
  wire logic [7:0] rdByte = (width_q == ebd_pkg::SZ_WORD && addr_q[0]) ? extDin[15:8] :
                            (width_q == ebd_pkg::SZ_BUS32) ? extDin[{addr_q[1:0], 3'h0} +: 8] :
                            extDin[7:0];
  logic [31:0] rdMerge;
  always_comb begin
    rdMerge = rdata_q;
    if (width_q == ebd_pkg::SZ_BYTE || size_q == ebd_pkg::SZ_BYTE) begin
      rdMerge[{rdOff, 3'h0} +: 8] = rdByte;
    end else if (width_q == ebd_pkg::SZ_WORD) begin
      rdMerge[{rdOff[1], 4'h0} +: 16] = extDin[15:0];
    end else begin
      rdMerge = extDin >> {addr_q[1:0], 3'h0};
    end
  end
  // sdram row address: beat address shifted down by the column bits, no column phase
  wire logic [25:0] beatAddr = {addr_q[25:2], curLow};
  wire logic [25:0] muxAddr = beatAddr >> sdramColBits;
  // ==========================================================
  // sequencer: one beat per wait window, beats in ascending order
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      state_q    <= EBD_IDLE;
      addr_q     <= 32'h0000_0000;
      size_q     <= 2'h0;
      width_q    <= 2'h0;
      write_q    <= 1'b0;
      wdata_q    <= 32'h0000_0000;
      rdata_q    <= 32'h0000_0000;
      waitLoad_q <= ebd_pkg::RESET_WAIT;
      waitCnt_q  <= ebd_pkg::RESET_WAIT;
      beat_q     <= 3'h0;
      beats_q    <= 3'h1;
      a0_q       <= 1'b0;
      a2_q       <= 1'b0;
      a3_q       <= 1'b0;
      a4_q       <= 1'b0;
      sd_q       <= 1'b0;
      burst_q    <= 1'b0;
      capEn_q    <= 1'b0;
    end else begin
      capEn_q <= beatEnd & ~write_q; // capture when the pins hold the beat
      if (capEn_q) begin
        rdata_q <= rdMerge;
      end
      unique case (state_q)
        EBD_IDLE: begin
          if (accept && extHit) begin
            state_q    <= EBD_ACCESS;
            addr_q     <= reqAddr;
            size_q     <= reqSize;
            width_q    <= busWidth;
            write_q    <= reqWrite;
            wdata_q    <= reqWdata;
            rdata_q    <= 32'h0000_0000;
            waitLoad_q <= waitSel;
            waitCnt_q  <= waitSel;
            beat_q     <= 3'h0;
            beats_q    <= beatsNeeded;
            a0_q       <= hitA0;
            a2_q       <= hitA2;
            a3_q       <= hitA3;
            a4_q       <= hitA4;
            sd_q       <= hitSd;
            burst_q    <= burstEn & hitA0;
          end
        end
        EBD_ACCESS: begin
          if (!beatEnd) begin
            waitCnt_q <= waitCnt_q - 4'h1;
          end else begin
            if (lastBeat) begin
              state_q <= EBD_DONE;
            end else begin
              beat_q    <= beat_q + 3'h1;
              waitCnt_q <= burst_q ? burstLoad : waitLoad_q;
            end
          end
        end
        EBD_DONE: begin
          state_q <= EBD_IDLE;
        end
        default: state_q <= EBD_IDLE;
      endcase
    end
  end
  // ==========================================================
  // registered pin drive; strobes active low, masks active high
  wire logic act = state_q == EBD_ACCESS;
  wire logic ord = act & ~sd_q;
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      extAddr               <= 26'h000_0000;
      extDout               <= 32'h0000_0000;
      extDoe                <= 1'b0;
      area0_chip_select_n   <= 1'b1;
      area2_chip_select_n   <= 1'b1;
      area3_chip_select_n   <= 1'b1;
      area4_chip_select_n   <= 1'b1;
      readStrobe_n          <= 1'b1;
      byte_write_strobes_n  <= 4'hf;
      row_strobe_upper_n    <= 1'b1;
      row_strobe_lower_n    <= 1'b1;
      column_strobe_upper_n <= 1'b1;
      column_strobe_lower_n <= 1'b1;
      sdramReadNotWrite     <= 1'b1;
      byte_mask_lane0       <= 1'b1;
      byte_mask_lane1       <= 1'b1;
      byte_mask_lane2       <= 1'b1;
      byte_mask_lane3       <= 1'b1;
      burstPitchTick        <= 1'b0;
      reqReady              <= 1'b0;
      rspValid              <= 1'b0;
      rspRdata              <= 32'h0000_0000;
      periphSel             <= 1'b0;
    end else begin
      extAddr               <= sd_q ? muxAddr : beatAddr;
      extDout               <= laneData;
      extDoe                <= act & write_q;
      area0_chip_select_n   <= ~(act & a0_q);
      area2_chip_select_n   <= ~(act & a2_q);
      area3_chip_select_n   <= ~(act & a3_q);
      area4_chip_select_n   <= ~(act & a4_q);
      readStrobe_n          <= ~(ord & ~write_q);
      byte_write_strobes_n  <= ~({4{ord & write_q}} & laneEn);
      row_strobe_upper_n    <= ~(act & sd_q);
      row_strobe_lower_n    <= ~(act & sd_q);
      column_strobe_upper_n <= ~(beatEnd & sd_q);
      column_strobe_lower_n <= ~(beatEnd & sd_q);
      sdramReadNotWrite     <= ~(act & sd_q & write_q);
      byte_mask_lane0       <= ~(act & sd_q & laneEn[0]);
      byte_mask_lane1       <= ~(act & sd_q & laneEn[1]);
      byte_mask_lane2       <= ~(act & sd_q & laneEn[2]);
      byte_mask_lane3       <= ~(act & sd_q & laneEn[3]);
      // burst pitch: one tick per beat, i.e. wait count clamped to 1..9 plus 1 clock
      burstPitchTick        <= beatEnd & burst_q;
      reqReady              <= accept;
      rspValid              <= (state_q == EBD_DONE) | (accept & hitA1);
      rspRdata              <= (state_q == EBD_DONE && capEn_q) ? rdMerge : 32'h0000_0000;
      periphSel             <= accept & hitA1;
    end
  end
endmodule

// ===== test/ebd_bridge_sva.sv
// ==========================================================
// port-level checks of area decode and strobe steering
module ebd_bridge_sva (
  input wire logic        clk_sys,
  input wire logic        rst,
  input wire logic        reqReady,
  input wire logic [31:0] reqAddr,
  input wire logic        periphSel,
  input wire logic        area0_chip_select_n,
  input wire logic        area2_chip_select_n,
  input wire logic        area3_chip_select_n,
  input wire logic        area4_chip_select_n,
  input wire logic        readStrobe_n,
  input wire logic [3:0]  byte_write_strobes_n,
  input wire logic        extDoe,
  input wire logic        width_mode_pin_low,
  input wire logic        width_mode_pin_high,
  input wire logic [1:0]  sdramAreas,
  input wire logic        row_strobe_upper_n,
  input wire logic        row_strobe_lower_n,
  input wire logic        burstPitchTick
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking dc @(posedge clk_sys); endclocking
  default disable iff (rst);
  // decoded helpers, selects gathered so one-hot is easy to state
  wire [3:0] selN = {area4_chip_select_n, area3_chip_select_n,
                     area2_chip_select_n, area0_chip_select_n};
  wire [2:0] code = reqAddr[28:26];
  wire       strobeOn = !readStrobe_n || !(&byte_write_strobes_n);
  one_area_a: assert property ($onehot0(~selN))
    else $error("more than one area select low");
  periph_quiet_a: assert property (periphSel |-> &selN && !strobeOn)
    else $error("peripheral access drove external pins");
  area0_sel_a: assert property (reqReady && code == 3'h0 |=> !area0_chip_select_n)
    else $error("area 0 select missing");
  area2_sel_a: assert property (reqReady && code == 3'h2 && !sdramAreas[0]
    |=> !area2_chip_select_n)
    else $error("area 2 select missing");
  area3_sel_a: assert property (reqReady && code == 3'h3 && !sdramAreas[1]
    |=> !area3_chip_select_n)
    else $error("area 3 select missing");
  area4_sel_a: assert property (reqReady && code == 3'h4 |=> !area4_chip_select_n)
    else $error("area 4 select missing");
  rd_wr_excl_a: assert property (!readStrobe_n |-> &byte_write_strobes_n)
    else $error("read and write strobes together");
  wr_drive_a: assert property (!(&byte_write_strobes_n) |-> extDoe)
    else $error("write strobe without data drive");
  narrow_lane_a: assert property (!area0_chip_select_n && width_mode_pin_low
    && !width_mode_pin_high |-> byte_write_strobes_n[3:1] == 3'h7)
    else $error("8-bit device used an upper lane");
  row_sdram_a: assert property (!(row_strobe_upper_n && row_strobe_lower_n)
    |-> sdramAreas != 2'h0)
    else $error("row strobe with no sdram area");
  burst_pitch_a: assert property (burstPitchTick |=> !burstPitchTick)
    else $error("burst pitch below two clocks");
  cover property (!area0_chip_select_n && !(&byte_write_strobes_n));
  cover property (periphSel);
  cover property (burstPitchTick);
endmodule

bind ebd_bridge ebd_bridge_sva chk_u (
  .clk_sys(clk_sys), .rst(rst), .reqReady(reqReady), .reqAddr(reqAddr),
  .periphSel(periphSel), .area0_chip_select_n(area0_chip_select_n),
  .area2_chip_select_n(area2_chip_select_n), .area3_chip_select_n(area3_chip_select_n),
  .area4_chip_select_n(area4_chip_select_n), .readStrobe_n(readStrobe_n),
  .byte_write_strobes_n(byte_write_strobes_n), .extDoe(extDoe),
  .width_mode_pin_low(width_mode_pin_low), .width_mode_pin_high(width_mode_pin_high),
  .sdramAreas(sdramAreas), .row_strobe_upper_n(row_strobe_upper_n),
  .row_strobe_lower_n(row_strobe_lower_n), .burstPitchTick(burstPitchTick));

// ===== test/ebd_mem_model.sv
// ==========================================================
// static memory on the far side, little-endian lanes
module ebd_mem_model (
  input  wire logic        clk_sys,
  input  wire logic [2:0]  devWidth,
  input  wire logic [25:0] extAddr,
  input  wire logic [31:0] extDout,
  input  wire logic        readStrobe_n,
  input  wire logic [3:0]  byte_write_strobes_n,
  output logic [31:0]      extDin
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0]  mem [int];
  logic [31:0] idlePat = 32'h5a5a_c3c3;
  logic [25:0] lastAddr = 26'h0;
  logic        wasOn = 1'b0;
  logic [61:0] beatQ [$];
  wire  [25:0] base = extAddr & ~26'(devWidth - 3'h1);
  wire         on = !readStrobe_n || !(&byte_write_strobes_n);
  // read lanes from the aligned device word; idle bus toggles so no stale match
  always @* begin
    extDin = idlePat;
    if (!readStrobe_n)
      for (int k = 0; k < 4; k++)
        if (k < devWidth)
          extDin[8*k +: 8] = mem.exists(int'(base) + k) ? mem[int'(base) + k] : 8'h00;
  end
  // capture written lanes and log the first cycle of each beat
  always @(posedge clk_sys) begin
    idlePat <= ~idlePat;
    for (int k = 0; k < 4; k++)
      if (k < devWidth && !byte_write_strobes_n[k])
        mem[int'(base) + k] = extDout[8*k +: 8];
    if (on && (!wasOn || extAddr != lastAddr))
      beatQ.push_back({extAddr, extDout, byte_write_strobes_n});
    wasOn <= on;
    lastAddr <= extAddr;
  end
endmodule

// ===== test/tb_ext_bus_area_decode_lane_steer.sv
module tb_ext_bus_area_decode_lane_steer;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk_sys = 1'b0, rst = 1'b1, reqValid = 1'b0, reqWrite = 1'b0, burstEn = 1'b0;
  logic [31:0] reqAddr = 32'h0, reqWdata = 32'h0, rspRdata, extDout, extDin;
  logic [1:0]  reqSize = 2'h1, sdramAreas = 2'h0, mode = 2'h1, a2w = 2'h0, a3w = 2'h0;
  logic [1:0]  a2s = 2'h0, a3s = 2'h0;
  logic [2:0]  a0w = 3'h0, a4w = 3'h0, devWidth = 3'h4;
  logic [3:0]  area4Size = 4'h0, byte_write_strobes_n;
  logic [25:0] extAddr;
  logic        reqReady, rspValid, periphSel, readStrobe_n, rowU_n, rowL_n, tick;
  int          n_fail = 0, tests_run = 0, periphCnt = 0, tickCnt = 0, rowCnt = 0;
  // ==========================================================
  // clock, design and far-side memory
  initial forever #25 clk_sys = ~clk_sys;
  ebd_bridge dut_u (.clk_sys(clk_sys), .rst(rst), .reqValid(reqValid), .reqAddr(reqAddr),
    .reqSize(reqSize), .reqWrite(reqWrite), .reqWdata(reqWdata), .burstEn(burstEn),
    .reqReady(reqReady), .rspValid(rspValid), .rspRdata(rspRdata), .periphSel(periphSel),
    .width_mode_pin_low(mode[0]), .width_mode_pin_high(mode[1]), .area0_wait_field(a0w),
    .area2_wait_field_high(a2w[1]), .area2_wait_field_low(a2w[0]),
    .area3_wait_field_high(a3w[1]), .area3_wait_field_low(a3w[0]), .area4_wait_field(a4w),
    .area2_size_field_high(a2s[1]), .area2_size_field_low(a2s[0]),
    .area3_size_field_high(a3s[1]), .area3_size_field_low(a3s[0]),
    .sdramAreas(sdramAreas), .sdramColBits(4'h1), .area4Size(area4Size),
    .extAddr(extAddr), .extDout(extDout), .extDoe(), .extDin(extDin),
    .area0_chip_select_n(), .area2_chip_select_n(), .area3_chip_select_n(),
    .area4_chip_select_n(), .readStrobe_n(readStrobe_n),
    .byte_write_strobes_n(byte_write_strobes_n), .row_strobe_upper_n(rowU_n),
    .row_strobe_lower_n(rowL_n), .column_strobe_upper_n(), .column_strobe_lower_n(),
    .sdramReadNotWrite(), .byte_mask_lane0(), .byte_mask_lane1(), .byte_mask_lane2(),
    .byte_mask_lane3(), .burstPitchTick(tick));
  ebd_mem_model mem_u (.clk_sys(clk_sys), .devWidth(devWidth), .extAddr(extAddr),
    .extDout(extDout), .readStrobe_n(readStrobe_n),
    .byte_write_strobes_n(byte_write_strobes_n), .extDin(extDin));
  // event counters for pulses the tasks cannot wait on directly
  always @(posedge clk_sys) begin
    periphCnt += (periphSel === 1'b1);
    tickCnt += (tick === 1'b1);
    rowCnt += (rowU_n === 1'b0 || rowL_n === 1'b0);
  end
  // ==========================================================
  // helpers
  task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // one request held until taken, then wait for the answer under a bound
  task automatic xfer(logic [31:0] a, int s, logic wr, logic [31:0] d,
                      output logic [31:0] r, output int lat);
    int n;
    reqValid <= 1'b1; reqAddr <= a; reqSize <= 2'(s == 4 ? 3 : s);
    reqWrite <= wr; reqWdata <= d;
    n = 0;
    do begin @(posedge clk_sys); n++; end while (reqReady !== 1'b1 && n < 100);
    reqValid <= 1'b0;
    lat = 0;
    while (rspValid !== 1'b1 && lat < 200) begin
      @(posedge clk_sys);
      lat++;
    end
    check("handshake bound", 32'(n < 100 && lat < 200), 32'h1);
    r = rspRdata;
    @(posedge clk_sys);
  endtask
  // write then read back one unit, checking beats, lanes and wait count
  task automatic op(int ar, int s);
    logic [31:0] a, d, r, ed, m;
    logic [61:0] bt;
    logic [3:0]  es;
    logic [1:0]  e;
    int          w, wt, nb, lat, ln;
    e = ar == 0 ? mode : ar == 2 ? a2s : ar == 3 ? a3s : area4Size[1:0];
    w = e == 2'h1 ? 1 : e == 2'h2 ? 2 : 4;
    wt = ar == 0 ? a0w : ar == 2 ? a2w : ar == 3 ? a3w : a4w;
    nb = s > w ? s / w : 1;
    a = {3'($urandom_range(7)), 3'(ar), 26'($urandom & ~(s - 1))};
    d = $urandom;
    m = s == 4 ? 32'hffff_ffff : (32'h1 << 8 * s) - 32'h1;
    devWidth <= 3'(w);
    mem_u.beatQ.delete();
    xfer(a, s, 1'b1, d, r, lat);
    check("write wait", 32'(lat), 32'(nb * (wt + 1) + 1));
    check("write beats", 32'(mem_u.beatQ.size()), 32'(nb));
    for (int k = 0; k < nb && mem_u.beatQ.size() > 0; k++) begin
      bt = mem_u.beatQ.pop_front();
      es = 4'hf; ed = 32'h0; m = 32'h0;
      for (int i = k * w; i < s && i < (k + 1) * w; i++) begin
        ln = (int'(a[3:0]) + i) % w;
        es[ln] = 1'b0; ed[8*ln +: 8] = d[8*i +: 8]; m[8*ln +: 8] = 8'hff;
      end
      check("beat address", 32'(bt[61:36]), 32'(a[25:0]) + 32'(nb > 1 ? k * w : 0));
      check("lane strobes", 32'(bt[3:0]), 32'(es));
      check("lane data", bt[35:4] & m, ed);
    end
    m = s == 4 ? 32'hffff_ffff : (32'h1 << 8 * s) - 32'h1;
    mem_u.beatQ.delete();
    xfer(a, s, 1'b0, 32'h0, r, lat);
    check("read wait", 32'(lat), 32'(nb * (wt + 1) + 1));
    check("read beats", 32'(mem_u.beatQ.size()), 32'(nb));
    check("read data", r & m, d & m);
  endtask
  // ==========================================================
  // main sequence: two strap and size sets, every external area and unit size
  initial begin
    logic [31:0] r;
    int          lat;
    void'($urandom(32'h9f22c7de));
    repeat (2) @(posedge clk_sys);
    rst <= 1'b0;
    for (int p = 0; p < 2; p++) begin
      mode <= p ? 2'h2 : 2'h1;
      a2s <= p ? 2'h0 : 2'h2; a3s <= p ? 2'h2 : 2'h1; area4Size <= p ? 4'h1 : 4'h0;
      a0w <= 3'($urandom); a4w <= 3'($urandom); a2w <= 2'($urandom); a3w <= 2'($urandom);
      repeat (4) @(posedge clk_sys);
      for (int ar = 0; ar < 5; ar++)
        if (ar != 1)
          for (int s = 1; s <= 4; s *= 2) op(ar, s);
    end
    // internal peripheral area: handed off, no external beat
    mem_u.beatQ.delete();
    xfer({3'h7, 3'h1, 26'h000_0100}, 4, 1'b0, 32'h0, r, lat);
    check("peripheral answer", 32'(lat), 32'h0);
    check("peripheral hand-off", 32'(periphCnt), 32'h1);
    check("peripheral beats", 32'(mem_u.beatQ.size()), 32'h0);
    // area 0 burst on the 16-bit strap: one pitch tick per beat
    burstEn <= 1'b1;
    xfer(32'h0000_0040, 4, 1'b0, 32'h0, r, lat);
    burstEn <= 1'b0;
    check("burst ticks", 32'(tickCnt), 32'h2);
    // sdram in areas 2 and 3 must drive row strobes
    for (int q = 0; q < 2; q++) begin
      sdramAreas <= 2'(1 << q);
      rowCnt = 0;
      xfer({3'h0, 3'(2 + q), 26'h000_0200}, 4, 1'b1, $urandom, r, lat);
      check("row strobe seen", 32'(rowCnt != 0), 32'h1);
    end
    give_verdict();
  end
  // watchdog well beyond the expected run of under two thousand cycles
  initial begin
    repeat (20000) @(posedge clk_sys);
    n_fail++;
    give_verdict();
  end
endmodule
